// ### design/banked_regfile.sv
// Banked register file address selection, pointer registers and stack
`include "regfile_cfg.svh"

// Operation
// RQ1: Upper selector nibble picks the 16-byte working group for 4-bit operands.
// RQ2: Lower selector nibble picks the bank; banks 0,1,2,3,D,F exist.
// RQ3: Bank field zero addresses normal bank 0 space.
// RQ4: Nonzero bank field swaps the low sixteen addresses to that bank; the code keeps 00h-03h in bank 0 for banks other than D and F.
// RQ5: Selector is read-write at FDh, reset to zero.
// RQ6: Scratch byte at FEh, read-write, reset value undefined.
// RQ7: Stack address is eight bits; stack accesses always target bank 0.
// RQ8: Push decrements before write; pop reads then increments.
// RQ9: Stack address points at newest item, the lowest address in use.
// RQ10: A call saves the program counter on the stack.
// RQ11: An interrupt saves program counter and flags on the stack.
// RQ12: Stack address at FFh, read-write, undefined reset, wrap unguarded.
// RQ13: Linear 004h-00Fh is storage reached only with bank 0.
// RQ14: Linear 010h-0EFh reached by 10h-EFh with bank 0, D or F.
// RQ15: Ranges 100-103, 1F0-203, 2F0-303, 3F0-3FF reachable only linearly.
// RQ16: D10h-DFFh reserved; 8-bit access with bank D goes to bank 0.
// RQ17: 8-bit F0h-FFh always reach bank 0 control registers.
// RQ18: 8-bit 00h-03h reach bank 0 ports unless bank D or F.
// RQ19: Every stack operation addresses bank 0 whatever the bank field.
// RQ20: Linear address is bank in top four bits, then 8-bit offset.
// RQ21: Reserved linear ranges ignore writes and read as harmless zero.
module banked_regfile (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [`AXI_AW-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [`AXI_AW-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Core register port
    input wire logic core_req,
    input wire regfile_pkg::op_e core_op,
    input wire logic [11:0] core_addr,
    input wire logic core_we,
    input wire logic [7:0] core_wdata,
    input wire logic [15:0] core_pc,
    input wire logic [7:0] core_flags,
    output logic core_ready,
    output logic core_ack,
    output logic [7:0] core_rdata,
    // Registers owned by other blocks
    output logic ext_req,
    output logic ext_we,
    output logic [11:0] ext_addr,
    output logic [7:0] ext_wdata,
    input wire logic [7:0] ext_rdata,
    // Selector fields for the rest of the core
    output logic [3:0] work_group,
    output logic [3:0] active_bank
);
    regfile_pkg::state_e state_ff, nxt_state;
    regfile_pkg::op_e op_ff;
    regfile_pkg::class_e cls_ff, act_cls;
    logic [7:0] sel_ff, user_ff, sp_ff, nxt_sel, nxt_user, nxt_sp;
    logic [11:0] lin_ff, act_lin;
    logic we_ff;
    logic [7:0] wdata_ff;
    logic [23:0] save_ff;
    logic [1:0] cnt_ff;
    logic rsv_ff;
    logic core_ready_ff, core_ack_ff;
    logic [7:0] core_rdata_ff;
    logic ext_req_ff, ext_we_ff;
    logic [11:0] ext_addr_ff;
    logic [7:0] ext_wdata_ff;
    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic aw_got_ff, w_got_ff;
    logic [9:0] wr_idx_ff;
    logic [7:0] wbyte_ff;
    logic wstrb0_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic [7:0] mem_rdata;

    function automatic regfile_pkg::class_e classify(input logic [11:0] lin);
        classify = regfile_pkg::CL_RSV; // [RQ21]
        if (lin >= `SEL_LIN && lin <= `SP_LIN)
            classify = regfile_pkg::CL_OWN;
        else if (lin <= `PORT_LIN_HI || (lin >= `CTRL_LIN_LO && lin < `SEL_LIN) ||
                 lin[11:4] == `BANKD_CTRL || lin[11:4] == `BANKF_CTRL)
            classify = regfile_pkg::CL_EXT;
        else if (lin <= `MEM_TOP)
            classify = regfile_pkg::CL_MEM; // [RQ13] [RQ15]
    endfunction : classify

    // Address resolution of the incoming request
    wire take = core_req && core_ready_ff;
    wire [3:0] bank = sel_ff[`BANK_HI:`BANK_LO]; // [RQ2]
    wire bank_df = (bank == `BANK_D) || (bank == `BANK_F);
    wire is_stack = core_op == regfile_pkg::OP_PUSH || core_op == regfile_pkg::OP_POP;
    wire is_save = core_op == regfile_pkg::OP_CALL || core_op == regfile_pkg::OP_IRQ;
    // Working operands land inside the group chosen by the upper nibble
    wire [7:0] a8 = (core_op == regfile_pkg::OP_WORK) ?
        {sel_ff[`GRP_HI:`GRP_LO], core_addr[3:0]} : core_addr[7:0]; // [RQ1]
    wire to_bank0 = (a8 >= `A8_CTRL_LO) || (bank == `BANK_0) || // [RQ17] [RQ3]
        (a8 <= `A8_PORT_HI && !bank_df) || // [RQ18]
        (a8 > `A8_LOW_HI && bank_df); // [RQ14] [RQ16]
    wire [11:0] lin8 = to_bank0 ? {`BANK_0, a8} : {bank, a8}; // [RQ4] [RQ20]
    wire [7:0] sp_dn = sp_ff - 8'h01;
    wire [11:0] lin_req = (core_op == regfile_pkg::OP_LINEAR) ? core_addr :
        (core_op == regfile_pkg::OP_PUSH) ? {`BANK_0, sp_dn} : // [RQ8] [RQ19]
        (core_op == regfile_pkg::OP_POP) ? {`BANK_0, sp_ff} : lin8; // [RQ9]
    wire we_req = (core_op == regfile_pkg::OP_PUSH) || is_save ||
        (core_we && !is_stack);

    // The access that executes this cycle
    wire in_save = state_ff == regfile_pkg::ST_SAVE;
    wire act_go = (state_ff == regfile_pkg::ST_EXEC) || in_save;
    wire act_we = in_save || we_ff;
    wire [7:0] act_wdata = in_save ? save_ff[7:0] : wdata_ff;
    assign act_lin = in_save ? {`BANK_0, sp_dn} : lin_ff; // [RQ7] [RQ19]
    assign act_cls = classify(act_lin);
    wire mem_en = act_go && act_cls == regfile_pkg::CL_MEM;

    regfile_mem #(
        .DEPTH(`MEM_DEPTH),
        .AW(`MEM_AW),
        .DW(8)
    ) u_mem (
        .clk(aclk),
        .en(mem_en),
        .we(act_we),
        .addr(act_lin[`MEM_AW-1:0]),
        .wdata(act_wdata),
        .rdata(mem_rdata)
    );

    // AXI4-Lite decode
    wire axi_wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
    wire wr_sel = wr_idx_ff == `SEL_IDX;
    wire wr_user = wr_idx_ff == `USER_IDX;
    wire wr_sp = wr_idx_ff == `SP_IDX;
    wire wr_ok = wr_sel || wr_user || wr_sp || wr_idx_ff == `STAT_IDX;
    wire axi_wr_sel = axi_wr_fire && wr_sel && wstrb0_ff;
    wire axi_wr_user = axi_wr_fire && wr_user && wstrb0_ff;
    wire axi_wr_sp = axi_wr_fire && wr_sp && wstrb0_ff;
    wire [9:0] rd_idx = araddr[`AXI_AW-1:2];
    wire rd_ok = rd_idx == `SEL_IDX || rd_idx == `USER_IDX || rd_idx == `SP_IDX ||
        rd_idx == `STAT_IDX;
    wire [7:0] rd_byte = (rd_idx == `SEL_IDX) ? sel_ff :
        (rd_idx == `USER_IDX) ? user_ff :
        (rd_idx == `SP_IDX) ? sp_ff :
        (rd_idx == `STAT_IDX) ? {6'h00, rsv_ff, !core_ready_ff} : 8'h00;

    // Own registers; a bus write wins over a core access in the same cycle
    wire core_wr = act_go && act_we;
    wire sp_dec = (take && core_op == regfile_pkg::OP_PUSH) || in_save; // [RQ8]
    wire sp_inc = state_ff == regfile_pkg::ST_RESP && op_ff == regfile_pkg::OP_POP;
    assign nxt_sel = axi_wr_sel ? wbyte_ff :
        (core_wr && act_lin == `SEL_LIN) ? act_wdata : sel_ff; // [RQ5]
    assign nxt_user = axi_wr_user ? wbyte_ff :
        (core_wr && act_lin == `USER_LIN) ? act_wdata : user_ff; // [RQ6]
    // Wrap on overflow is deliberately unguarded
    assign nxt_sp = axi_wr_sp ? wbyte_ff :
        (core_wr && act_lin == `SP_LIN) ? act_wdata :
        sp_dec ? sp_dn :
        sp_inc ? sp_ff + 8'h01 : sp_ff; // [RQ12] [RQ8]

    wire [7:0] own_val = (lin_ff == `SEL_LIN) ? sel_ff :
        (lin_ff == `USER_LIN) ? user_ff : sp_ff;
    wire [7:0] resp_val = we_ff ? 8'h00 :
        (cls_ff == regfile_pkg::CL_MEM) ? mem_rdata :
        (cls_ff == regfile_pkg::CL_EXT) ? ext_rdata :
        (cls_ff == regfile_pkg::CL_OWN) ? own_val : 8'h00; // [RQ21]

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            regfile_pkg::ST_IDLE:
                if (take)
                    nxt_state = is_save ? regfile_pkg::ST_SAVE : regfile_pkg::ST_EXEC;
            regfile_pkg::ST_EXEC:
                nxt_state = regfile_pkg::ST_RESP;
            regfile_pkg::ST_SAVE:
                if (cnt_ff == 2'h1)
                    nxt_state = regfile_pkg::ST_RESP;
            regfile_pkg::ST_RESP:
                nxt_state = regfile_pkg::ST_IDLE;
            default:
                nxt_state = regfile_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_ff <= regfile_pkg::ST_IDLE;
            sel_ff <= `SEL_RESET;
            user_ff <= `USER_RESET;
            sp_ff <= `SP_RESET;
            core_ready_ff <= 1'b0;
            core_ack_ff <= 1'b0;
            rsv_ff <= 1'b0;
            ext_req_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            sel_ff <= nxt_sel;
            user_ff <= nxt_user;
            sp_ff <= nxt_sp;
            core_ready_ff <= nxt_state == regfile_pkg::ST_IDLE;
            core_ack_ff <= state_ff == regfile_pkg::ST_RESP;
            ext_req_ff <= act_go && act_cls == regfile_pkg::CL_EXT;
            if (act_go)
                rsv_ff <= act_cls == regfile_pkg::CL_RSV;
        end
    end

    // Request latch and data path, no reset needed
    always_ff @(posedge aclk)
    begin
        if (take)
        begin
            op_ff <= core_op;
            lin_ff <= lin_req;
            we_ff <= we_req;
            wdata_ff <= core_wdata;
            // Return address low byte goes deepest, flags end on top
            save_ff <= {core_flags, core_pc[15:8], core_pc[7:0]}; // [RQ10] [RQ11]
            cnt_ff <= (core_op == regfile_pkg::OP_IRQ) ? `IRQ_BYTES : `CALL_BYTES;
        end
        else if (in_save)
        begin
            save_ff <= {8'h00, save_ff[23:8]};
            cnt_ff <= cnt_ff - 2'h1;
        end
        if (act_go)
            cls_ff <= act_cls;
        if (state_ff == regfile_pkg::ST_RESP)
            core_rdata_ff <= resp_val;
        ext_we_ff <= act_we;
        ext_addr_ff <= act_lin;
        ext_wdata_ff <= act_wdata;
    end

    // AXI4-Lite slave, one write and one read outstanding
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `RESP_OKAY;
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rresp_ff <= `RESP_OKAY;
            rdata_ff <= 32'h00000000;
        end
        else
        begin
            awready_ff <= !aw_got_ff && !(awvalid && awready_ff);
            wready_ff <= !w_got_ff && !(wvalid && wready_ff);
            if (awvalid && awready_ff)
                aw_got_ff <= 1'b1;
            if (wvalid && wready_ff)
                w_got_ff <= 1'b1;
            if (axi_wr_fire)
            begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (bvalid_ff && bready)
            begin
                bvalid_ff <= 1'b0;
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
            end
            arready_ff <= !rvalid_ff && !(arvalid && arready_ff);
            if (arvalid && arready_ff)
            begin
                rvalid_ff <= 1'b1;
                rdata_ff <= {24'h000000, rd_byte};
                rresp_ff <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (rvalid_ff && rready)
                rvalid_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (awvalid && awready_ff)
            wr_idx_ff <= awaddr[`AXI_AW-1:2];
        if (wvalid && wready_ff)
        begin
            wbyte_ff <= wdata[7:0];
            wstrb0_ff <= wstrb[0];
        end
    end

    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;
    assign core_ready = core_ready_ff;
    assign core_ack = core_ack_ff;
    assign core_rdata = core_rdata_ff;
    assign ext_req = ext_req_ff;
    assign ext_we = ext_we_ff;
    assign ext_addr = ext_addr_ff;
    assign ext_wdata = ext_wdata_ff;
    assign work_group = sel_ff[`GRP_HI:`GRP_LO];
    assign active_bank = sel_ff[`BANK_HI:`BANK_LO];

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_push_pre_dec: // [RQ8]
    assert property ((take && core_op == regfile_pkg::OP_PUSH && !axi_wr_sp) |=>
        (sp_ff == $past(sp_ff) - 8'h01 && lin_ff == {4'h0, sp_ff}))
    else $error("push did not pre-decrement the stack address");

    a_pop_post_inc: // [RQ8]
    assert property ((sp_inc && !axi_wr_sp && !(core_wr && act_lin == `SP_LIN)) |=>
        sp_ff == $past(sp_ff) + 8'h01)
    else $error("pop did not post-increment the stack address");

    a_stack_bank_zero: // [RQ19]
    assert property ((act_go && (in_save || op_ff == regfile_pkg::OP_PUSH ||
        op_ff == regfile_pkg::OP_POP)) |-> act_lin[11:8] == 4'h0)
    else $error("stack access left bank 0");

    a_ctrl_bank_free: // [RQ17]
    assert property ((take && core_op == regfile_pkg::OP_REG8 && core_addr[7:4] == 4'hF) |=>
        lin_ff == {4'h0, $past(core_addr[7:0])})
    else $error("control address not mapped to bank 0");

    a_low_swap: // [RQ4]
    assert property ((take && core_op == regfile_pkg::OP_REG8 && core_addr[7:0] <= 8'h0F &&
        bank != 4'h0 && (bank_df || core_addr[7:0] > 8'h03)) |=>
        lin_ff[11:8] == $past(bank))
    else $error("low addresses not swapped to selected bank");

    a_group_select: // [RQ1]
    assert property ((take && core_op == regfile_pkg::OP_WORK) |=>
        lin_ff[7:0] == {$past(sel_ff[7:4]), $past(core_addr[3:0])})
    else $error("working operand outside selected group");

    a_access_answer:
    assert property ((take && !is_save) |-> ##1 !core_ready ##1 !core_ack ##1
        (core_ack && core_ready))
    else $error("core access not answered in three cycles");

    a_irq_three_bytes: // [RQ11]
    assert property ((take && core_op == regfile_pkg::OP_IRQ) ##1 (!axi_wr_sp)[*3] |=>
        (sp_ff == $past(sp_ff, 4) - 8'h03 && state_ff == regfile_pkg::ST_RESP))
    else $error("interrupt save did not push three bytes");

    a_call_two_bytes: // [RQ10]
    assert property ((take && core_op == regfile_pkg::OP_CALL) ##1 (!axi_wr_sp)[*2] |=>
        (sp_ff == $past(sp_ff, 3) - 8'h02 && state_ff == regfile_pkg::ST_RESP))
    else $error("call save did not push two bytes");

    a_selector_reset: // [RQ5]
    assert property ($rose(aresetn) |-> sel_ff == 8'h00)
    else $error("selector not cleared by reset");
endmodule : banked_regfile

// ### design/regfile_cfg.svh
// Offsets, field positions, reset values and counts of the banked register file
`ifndef REGFILE_CFG_SVH
`define REGFILE_CFG_SVH
`define AXI_AW 12
`define STAT_IDX 10'h000
`define SEL_IDX 10'h0FD
`define USER_IDX 10'h0FE
`define SP_IDX 10'h0FF
`define SEL_LIN 12'h0FD
`define USER_LIN 12'h0FE
`define SP_LIN 12'h0FF
`define SEL_RESET 8'h00
`define USER_RESET 8'h00
`define SP_RESET 8'h00
`define GRP_HI 7
`define GRP_LO 4
`define BANK_HI 3
`define BANK_LO 0
`define BANK_0 4'h0
`define BANK_D 4'hD
`define BANK_F 4'hF
`define A8_PORT_HI 8'h03
`define A8_LOW_HI 8'h0F
`define A8_CTRL_LO 8'hF0
`define PORT_LIN_HI 12'h003
`define CTRL_LIN_LO 12'h0F0
`define BANKD_CTRL 8'hD0
`define BANKF_CTRL 8'hF0
`define MEM_TOP 12'h3FF
`define MEM_DEPTH 1024
`define MEM_AW 10
`define CALL_BYTES 2'h2
`define IRQ_BYTES 2'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### design/regfile_mem.sv
// Single-port byte storage with registered read data
module regfile_mem #(
    parameter int DEPTH = 1024,
    parameter int AW = 10,
    parameter int DW = 8
) (
    // Clock
    input wire logic clk,
    // Access
    input wire logic en,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem_ff [DEPTH];
    logic [DW-1:0] rdata_ff;

    // Contents are left unreset: the storage is undefined after reset
    always_ff @(posedge clk)
    begin
        if (en && we)
            mem_ff[addr] <= wdata;
        if (en && !we)
            rdata_ff <= mem_ff[addr];
    end

    assign rdata = rdata_ff;
endmodule : regfile_mem

// ### design/regfile_pkg.sv
// Types shared by the banked register file
package regfile_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_EXEC = 4'h2,
        ST_SAVE = 4'h4,
        ST_RESP = 4'h8
    } state_e;
    typedef enum logic [2:0] {
        OP_REG8 = 3'h0,
        OP_WORK = 3'h1,
        OP_LINEAR = 3'h2,
        OP_PUSH = 3'h3,
        OP_POP = 3'h4,
        OP_CALL = 3'h5,
        OP_IRQ = 3'h6
    } op_e;
    typedef enum logic [1:0] {
        CL_MEM = 2'h0,
        CL_OWN = 2'h1,
        CL_EXT = 2'h2,
        CL_RSV = 2'h3
    } class_e;
endpackage : regfile_pkg

// ### test/testbench.sv
// Self-checking bench for the banked register file, driven over AXI4-Lite and the core port
`include "regfile_cfg.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, awready, wvalid = 1'b0, wready, bvalid, bready = 1'b0;
    logic arvalid = 1'b0, arready, rvalid, rready = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [3:0] wstrb = 4'h1;
    logic [1:0] bresp, rresp;
    logic core_req = 1'b0, core_we = 1'b0, core_ready, core_ack;
    regfile_pkg::op_e core_op = regfile_pkg::OP_REG8;
    logic [11:0] core_addr = 12'h000;
    logic [7:0] core_wdata = 8'h00, core_flags = 8'h00, core_rdata;
    logic [15:0] core_pc = 16'h0000;
    logic ext_req, ext_we;
    logic [11:0] ext_addr;
    logic [7:0] ext_wdata;
    logic [7:0] ext_rdata = 8'hE5;
    logic [3:0] work_group, active_bank;
    logic [7:0] c_rd;
    logic [11:0] x_addr;
    logic [8:0] x_wr;
    logic [3:0] strb = 4'h1;
    int miscompares = 0;
    int cmp_count = 0;

    banked_regfile banked_regfile_i (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .core_req(core_req), .core_op(core_op),
        .core_addr(core_addr), .core_we(core_we), .core_wdata(core_wdata), .core_pc(core_pc),
        .core_flags(core_flags), .core_ready(core_ready), .core_ack(core_ack),
        .core_rdata(core_rdata), .ext_req(ext_req), .ext_we(ext_we), .ext_addr(ext_addr),
        .ext_wdata(ext_wdata), .ext_rdata(ext_rdata), .work_group(work_group),
        .active_bank(active_bank));

    always #2 aclk = ~aclk;

    task automatic check(input string name, input logic [11:0] exp, input logic [11:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results

    // Address and data are offered together; each is dropped at its own take
    task automatic awr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= {24'h00_0000, d};
        wstrb <= strb;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            if (!aw_ok && awready === 1'b1)
            begin
                awvalid <= 1'b0;
                aw_ok = 1'b1;
            end
            if (!w_ok && wready === 1'b1)
            begin
                wvalid <= 1'b0;
                w_ok = 1'b1;
            end
        end
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
        end
        while (bvalid !== 1'b1);
        bready <= 1'b0;
        check("bresp", {10'h000, er}, {10'h000, bresp});
    endtask : awr

    task automatic ard(input logic [11:0] a, input logic [7:0] exp, input logic [1:0] er,
        input string name);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        do
        begin
            @(posedge aclk);
        end
        while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
        end
        while (rvalid !== 1'b1);
        rready <= 1'b0;
        check(name, {4'h0, exp}, rdata[11:0]);
        check("rresp", {10'h000, er}, {10'h000, rresp});
    endtask : ard

    task automatic core(input regfile_pkg::op_e op, input logic [11:0] a, input logic we,
        input logic [7:0] d, input logic [15:0] pc = 16'h0000, input logic [7:0] fl = 8'h00);
        x_addr = 12'hEEE;
        x_wr = 9'h000;
        @(posedge aclk);
        core_req <= 1'b1;
        core_op <= op;
        core_addr <= a;
        core_we <= we;
        core_wdata <= d;
        core_pc <= pc;
        core_flags <= fl;
        do
        begin
            @(posedge aclk);
        end
        while (core_ready !== 1'b1);
        core_req <= 1'b0;
        do
        begin
            @(posedge aclk);
            if (ext_req === 1'b1)
            begin
                x_addr = ext_addr;
                x_wr = {ext_we, ext_wdata};
            end
        end
        while (core_ack !== 1'b1);
        c_rd = core_rdata;
    endtask : core

    task automatic r8(input logic [11:0] a, input logic [7:0] d);
        core(regfile_pkg::OP_REG8, a, 1'b1, d);
    endtask : r8

    task automatic lchk(input logic [11:0] a, input logic [7:0] exp, input string name);
        core(regfile_pkg::OP_LINEAR, a, 1'b0, 8'h00);
        check(name, {4'h0, exp}, {4'h0, c_rd});
    endtask : lchk

    initial
    begin
        #100000;
        miscompares++;
        results();
    end

    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        ard(12'h3F4, 8'h00, `RESP_OKAY, "selector_reset");
        awr(12'h3F4, 8'hA5, `RESP_OKAY);
        ard(12'h3F4, 8'hA5, `RESP_OKAY, "selector");
        check("work_group", 12'h00A, {8'h00, work_group});
        check("active_bank", 12'h005, {8'h00, active_bank});
        awr(12'h3F8, 8'h3C, `RESP_OKAY);
        ard(12'h3F8, 8'h3C, `RESP_OKAY, "scratch");
        strb = 4'h0;
        awr(12'h3F8, 8'hFF, `RESP_OKAY);
        strb = 4'h1;
        ard(12'h3F8, 8'h3C, `RESP_OKAY, "scratch_nostrb");
        awr(12'h800, 8'h11, `RESP_SLVERR);
        ard(12'h800, 8'h00, `RESP_SLVERR, "unmapped");
        $display("Test register access done");
        awr(12'h3F4, 8'h00, `RESP_OKAY);
        r8(12'h010, 8'h11);
        lchk(12'h010, 8'h11, "bank0_10");
        r8(12'h005, 8'h55);
        lchk(12'h005, 8'h55, "bank0_05");
        awr(12'h3F4, 8'h0D, `RESP_OKAY);
        core(regfile_pkg::OP_REG8, 12'h010, 1'b0, 8'h00);
        check("bankd_10", 12'h011, {4'h0, c_rd});
        r8(12'h020, 8'h22);
        lchk(12'h020, 8'h22, "bankd_20");
        core(regfile_pkg::OP_REG8, 12'h002, 1'b0, 8'h00);
        check("bankd_ext", 12'hD02, x_addr);
        check("ext_data", 12'h0E5, {4'h0, c_rd});
        awr(12'h3F4, 8'h01, `RESP_OKAY);
        r8(12'h005, 8'h66);
        lchk(12'h105, 8'h66, "bank1_05");
        lchk(12'h005, 8'h55, "bank0_kept");
        core(regfile_pkg::OP_REG8, 12'h0FD, 1'b0, 8'h00);
        check("ctrl_fd", 12'h001, {4'h0, c_rd});
        core(regfile_pkg::OP_REG8, 12'h0F1, 1'b0, 8'h00);
        check("ctrl_f1", 12'h0F1, x_addr);
        core(regfile_pkg::OP_REG8, 12'h0F3, 1'b1, 8'h5C);
        check("ext_write_addr", 12'h0F3, x_addr);
        check("ext_write", 12'h15C, {3'h0, x_wr});
        core(regfile_pkg::OP_REG8, 12'h002, 1'b0, 8'h00);
        check("port_02", 12'h002, x_addr);
        awr(12'h3F4, 8'h23, `RESP_OKAY);
        core(regfile_pkg::OP_WORK, 12'h001, 1'b1, 8'h77);
        lchk(12'h321, 8'h77, "work_r1");
        awr(12'h3F4, 8'h0F, `RESP_OKAY);
        core(regfile_pkg::OP_REG8, 12'h000, 1'b0, 8'h00);
        check("bankf_00", 12'hF00, x_addr);
        core(regfile_pkg::OP_LINEAR, 12'h1F5, 1'b1, 8'h5A);
        lchk(12'h1F5, 8'h5A, "lin_1f5");
        core(regfile_pkg::OP_LINEAR, 12'h500, 1'b1, 8'h42);
        lchk(12'h500, 8'h00, "reserved");
        ard(12'h000, 8'h02, `RESP_OKAY, "status_rsv");
        $display("Test bank map done");
        awr(12'h3F4, 8'h01, `RESP_OKAY);
        awr(12'h3FC, 8'h80, `RESP_OKAY);
        core(regfile_pkg::OP_PUSH, 12'h000, 1'b1, 8'hAB);
        ard(12'h3FC, 8'h7F, `RESP_OKAY, "sp_push");
        lchk(12'h07F, 8'hAB, "push_mem");
        core(regfile_pkg::OP_POP, 12'h000, 1'b0, 8'h00);
        check("pop_data", 12'h0AB, {4'h0, c_rd});
        ard(12'h3FC, 8'h80, `RESP_OKAY, "sp_pop");
        core(regfile_pkg::OP_CALL, 12'h000, 1'b0, 8'h00, 16'h1234);
        ard(12'h3FC, 8'h7E, `RESP_OKAY, "sp_call");
        lchk(12'h07F, 8'h34, "call_lo");
        lchk(12'h07E, 8'h12, "call_hi");
        core(regfile_pkg::OP_IRQ, 12'h000, 1'b0, 8'h00, 16'h5678, 8'h9A);
        ard(12'h3FC, 8'h7B, `RESP_OKAY, "sp_irq");
        lchk(12'h07D, 8'h78, "irq_lo");
        lchk(12'h07C, 8'h56, "irq_hi");
        lchk(12'h07B, 8'h9A, "irq_flags");
        // Unguarded wrap: popping from the top reads the pointer itself
        awr(12'h3FC, 8'hFF, `RESP_OKAY);
        core(regfile_pkg::OP_POP, 12'h000, 1'b0, 8'h00);
        check("wrap_data", 12'h0FF, {4'h0, c_rd});
        ard(12'h3FC, 8'h00, `RESP_OKAY, "sp_wrap");
        $display("Test stack done");
        results();
    end
endmodule : testbench
